//--- common/qbp_pkg.sv
// shared constants and types of the quasi-bidirectional port array
package qbp_pkg;

  // ==========================================================
  // sizes and reset values
  localparam int unsigned QBP_NPORT     = 6;
  localparam logic [7:0]  QBP_LATCH_RST = 8'hff;
  localparam logic [7:0]  QBP_ALL_ZERO  = 8'h00;

  // ==========================================================
  // timing: one phase is one oscillator period, one clk cycle
  localparam int unsigned QBP_CLK_NS    = 40;
  localparam int unsigned QBP_OSC_NS    = 40;
  localparam int unsigned QBP_PHASE_CYC =
    (QBP_OSC_NS / QBP_CLK_NS < 1) ? 1 : QBP_OSC_NS / QBP_CLK_NS;
  localparam int unsigned QBP_MC_OSC    = 12;
  localparam logic [3:0]  QBP_LAST_PH   = 4'(QBP_MC_OSC - 1);
  localparam logic [3:0]  QBP_S1P1      = 4'h0;
  localparam logic [3:0]  QBP_S1P2      = 4'h1;
  localparam logic [3:0]  QBP_S2P1      = 4'h2;
  localparam logic [3:0]  QBP_RST_SAMP  = 4'h9;

  // ==========================================================
  // port indices
  localparam logic [2:0] QBP_PORT_ZERO  = 3'h0;
  localparam logic [2:0] QBP_PORT_ONE   = 3'h1;
  localparam logic [2:0] QBP_PORT_TWO   = 3'h2;
  localparam logic [2:0] QBP_PORT_THREE = 3'h3;

  // ==========================================================
  // alternate functions: bit positions
  localparam int unsigned QBP_P1_IRQ3_CC0   = 0;
  localparam int unsigned QBP_P1_IRQ4_CC1   = 1;
  localparam int unsigned QBP_P1_IRQ5_CC2   = 2;
  localparam int unsigned QBP_P1_IRQ6_CC3   = 3;
  localparam int unsigned QBP_P1_IRQ_TWO    = 4;
  localparam int unsigned QBP_P1_T2_RELOAD  = 5;
  localparam int unsigned QBP_P1_SYSCLK_OUT = 6;
  localparam int unsigned QBP_P1_T2_INPUT   = 7;
  localparam int unsigned QBP_P3_SER_RX     = 0;
  localparam int unsigned QBP_P3_SER_TX     = 1;
  localparam int unsigned QBP_P3_IRQ_ZERO   = 2;
  localparam int unsigned QBP_P3_IRQ_ONE    = 3;
  localparam int unsigned QBP_P3_T0_INPUT   = 4;
  localparam int unsigned QBP_P3_T1_INPUT   = 5;
  localparam int unsigned QBP_P3_XDATA_WSTB = 6;
  localparam int unsigned QBP_P3_XDATA_RSTB = 7;
  // bits whose alternate output is gated by the latch
  localparam logic [7:0]  QBP_P1_ALT_MASK   = 8'hf0;
  localparam logic [7:0]  QBP_P3_ALT_MASK   = 8'hff;

  // ==========================================================
  // instruction kind presented with a port read
  typedef enum logic [3:0] {
    op_plain_read,
    logical_and_op,
    logical_or_op,
    logical_xor_op,
    jump_bit_set_clear_op,
    complement_bit_op,
    op_increment,
    op_decrement,
    decrement_jump_nonzero_op,
    op_move_carry_bit,
    op_clear_bit,
    op_set_bit
  } qbp_op_t;

  function automatic logic qbp_is_rmw(input qbp_op_t op);
    return op != op_plain_read;
  endfunction : qbp_is_rmw

endpackage : qbp_pkg

//--- logic/qbp_phase_gen.sv
// state/phase sequencer and reset pin filter
`timescale 1ns/100ps
`default_nettype none
module qbp_phase_gen
  import qbp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       ext_reset_n,
  output logic      [3:0] phase_cnt,
  output logic            pin_reset
);

  logic [3:0] cnt_ff;
  logic       meta_ff;
  logic       sync_ff;
  logic       low_seen_ff;
  logic       irst_ff;

  // ==========================================================
  // twelve phases per machine cycle, S1P1 = 0 .. S6P2 = 11
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_ff <= QBP_S1P1;
    end else if (cnt_ff == QBP_LAST_PH) begin
      cnt_ff <= QBP_S1P1;
    end else begin
      cnt_ff <= cnt_ff + 4'h1;
    end
  end

  // ==========================================================
  // reset pin: two flops, then one sample per machine cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
    end else begin
      meta_ff <= ext_reset_n;
      sync_ff <= meta_ff;
    end
  end

  // a single low sample is treated as noise
  always_ff @(posedge clk) begin
    if (reset) begin
      low_seen_ff <= 1'b0;
      irst_ff     <= 1'b0;
    end else if (cnt_ff == QBP_RST_SAMP) begin
      if (sync_ff) begin
        low_seen_ff <= 1'b0;
        irst_ff     <= 1'b0;
      end else begin
        low_seen_ff <= 1'b1;
        irst_ff     <= irst_ff | low_seen_ff;
      end
    end
  end

  assign phase_cnt = cnt_ff;
  assign pin_reset = irst_ff;

endmodule : qbp_phase_gen
`default_nettype wire

//--- logic/qbp_port_unit.sv
// one 8-bit port: latch, output buffer, input synchroniser
`timescale 1ns/100ps
`default_nettype none
module qbp_port_unit
  import qbp_pkg::*;
#(
  parameter bit OPEN_DRAIN = 1'b0,
  parameter bit HAS_STRONG = 1'b1
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       load_ph1,
  input  wire logic       s1_start,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  input  wire logic       force_ones,
  input  wire logic       ovr_en,
  input  wire logic [7:0] ovr_val,
  input  wire logic       ovr_full,
  input  wire logic [7:0] alt_out,
  input  wire logic [7:0] pin_in,
  output logic      [7:0] latch_q,
  output logic      [7:0] pin_sync,
  output logic      [7:0] pin_out,
  output logic      [7:0] pin_oe,
  output logic      [7:0] pin_strong
);

  logic [7:0] latch_ff;
  logic [7:0] meta_ff;
  logic [7:0] sync_ff;
  logic [7:0] out_ff;
  logic [7:0] oe_ff;
  logic [7:0] strong_ff;
  logic [7:0] nxt_latch;
  logic [7:0] nxt_val;
  logic [7:0] nxt_strong;
  logic [7:0] nxt_oe;

  // ==========================================================
  // latch: bus ones during external access win over a write
  always_comb begin
    nxt_latch = latch_ff;
    if (force_ones) begin
      nxt_latch = QBP_LATCH_RST;
    end else if (wr_en) begin
      nxt_latch = wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      latch_ff <= QBP_LATCH_RST;
    end else begin
      latch_ff <= nxt_latch;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_ff <= QBP_LATCH_RST;
      sync_ff <= QBP_LATCH_RST;
    end else begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
    end
  end

  // ==========================================================
  // output buffer, loaded only on entry to a phase 1
  always_comb begin
    nxt_val    = ovr_en ? ovr_val : (nxt_latch & alt_out);
    nxt_strong = QBP_ALL_ZERO;
    if (HAS_STRONG) begin
      if (ovr_en) begin
        nxt_strong = ovr_val;
      end else if (s1_start) begin
        nxt_strong = nxt_val & ~out_ff;
      end
    end
    if (OPEN_DRAIN) begin
      nxt_oe = (ovr_en && ovr_full) ? QBP_LATCH_RST : ~nxt_val;
    end else begin
      nxt_oe = ~nxt_val | nxt_strong;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      out_ff    <= QBP_LATCH_RST;
      oe_ff     <= QBP_ALL_ZERO;
      strong_ff <= QBP_ALL_ZERO;
    end else if (load_ph1) begin
      out_ff    <= nxt_val;
      oe_ff     <= nxt_oe;
      strong_ff <= nxt_strong;
    end
  end

  assign latch_q    = latch_ff;
  assign pin_sync   = sync_ff;
  assign pin_out    = out_ff;
  assign pin_oe     = oe_ff;
  assign pin_strong = strong_ff;

endmodule : qbp_port_unit
`default_nettype wire

//--- logic/qbp_port_array.sv
// six quasi-bidirectional ports with external bus takeover
`timescale 1ns/100ps
`default_nettype none

// How it works
// - machine cycle is twelve phases, S1P1 through S6P2, one clock each
// - reset loads every port latch with all ones
// - reset also presets the pin buffers and clears pending write and read data
// - latch loads on write strobe; reads return latch or pin level
// - read-modify-write reads of a port return the latch
// - bit writes modify one bit of the latch byte, rewrite whole byte
// - logic, jump-clear, complement, inc, dec, bit ops use latch path
// - latch updates at S6P2, pin follows at next S1P1
// - zero-to-one on ports one to five adds strong pullup during S1
// - port two address ones keep strong pullup whole external cycle
// - external access drives port zero, and port two on 16-bit addresses; port zero latch gets ones
// - port zero muxes low address and data; port two high address
// - port zero, and port two on 16-bit addresses, are not general I/O while bus
// - alternate outputs reach pin only while latch bit holds one
// - live pin level of ports one, three feeds alternate inputs
// - port one bits: irqs, capture/compare, reload, clock out, timer
// - port three bits: serial, irqs, timer inputs, data strobes
// - latch one turns off pull-down; weak pullup holds ports one-five
// - port zero open drain, pullup only emitting bus ones
module qbp_port_array
  import qbp_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            reset,
  input  wire logic            ext_reset_n,
  input  wire logic            wr_req,
  input  wire logic      [2:0] wr_port,
  input  wire logic      [7:0] wr_data,
  input  wire logic            wr_bit,
  input  wire logic      [2:0] wr_bit_idx,
  input  wire logic            wr_bit_val,
  input  wire logic            rd_req,
  input  wire logic      [2:0] rd_port,
  input  wire qbp_pkg::qbp_op_t rd_op,
  input  wire logic            ext_cycle,
  input  wire logic            ext_addr16,
  input  wire logic     [15:0] ext_addr,
  input  wire logic            ext_data_phase,
  input  wire logic            ext_drive,
  input  wire logic      [7:0] ext_wdata,
  input  wire logic      [7:0] alt_out_p1,
  input  wire logic      [7:0] alt_out_p3,
  input  wire logic [5:0][7:0] pin_in,
  output logic      [5:0][7:0] pin_out,
  output logic      [5:0][7:0] pin_oe,
  output logic      [5:0][7:0] pin_strong,
  output logic           [7:0] rd_data,
  output logic                 rd_valid,
  output logic                 wr_done,
  output logic           [7:0] alt_in_p1,
  output logic           [7:0] alt_in_p3,
  output logic           [7:0] ext_rdata,
  output logic           [3:0] mc_phase,
  output logic                 pin_reset_active
);

  logic [3:0]      cnt_w;
  logic            irst_w;
  logic            core_rst;
  logic            load_ph1;
  logic            s1_start;
  logic            commit;
  logic            pend_ff;
  logic [2:0]      pend_port_ff;
  logic [7:0]      pend_data_ff;
  logic            pend_bit_ff;
  logic [2:0]      pend_idx_ff;
  logic            pend_val_ff;
  logic [7:0]      wbyte;
  logic [7:0]      rd_data_ff;
  logic            rd_valid_ff;
  logic            wr_done_ff;
  logic [5:0][7:0] latch_w;
  logic [5:0][7:0] sync_w;
  logic [5:0]      ovr_en_w;
  logic [5:0][7:0] ovr_val_w;
  logic [5:0][7:0] alt_w;
  logic            p0_full;

  // ==========================================================
  // sequencing and reset
  qbp_phase_gen u_phase (
    .clk         (clk),
    .reset       (reset),
    .ext_reset_n (ext_reset_n),
    .phase_cnt   (cnt_w),
    .pin_reset   (irst_w)
  );

  assign core_rst = reset | irst_w;
  // buffers sample only on the edge into an even (phase 1) count
  assign load_ph1 = cnt_w[0];
  assign s1_start = cnt_w == QBP_LAST_PH;
  assign commit   = pend_ff && (cnt_w == QBP_LAST_PH);

  // ==========================================================
  // write path: held until S6P2, a newer request replaces it
  always_ff @(posedge clk) begin
    if (core_rst) begin
      pend_ff      <= 1'b0;
      pend_port_ff <= QBP_PORT_ZERO;
      pend_data_ff <= QBP_ALL_ZERO;
      pend_bit_ff  <= 1'b0;
      pend_idx_ff  <= 3'h0;
      pend_val_ff  <= 1'b0;
    end else if (wr_req) begin
      pend_ff      <= 1'b1;
      pend_port_ff <= wr_port;
      pend_data_ff <= wr_data;
      pend_bit_ff  <= wr_bit;
      pend_idx_ff  <= wr_bit_idx;
      pend_val_ff  <= wr_bit_val;
    end else if (commit) begin
      pend_ff <= 1'b0;
    end
  end

  // whole latch byte is read so other bits survive unchanged
  always_comb begin
    wbyte = pend_data_ff;
    if (pend_bit_ff) begin
      wbyte = (pend_port_ff < 3'(QBP_NPORT)) ? latch_w[pend_port_ff]
                                             : QBP_ALL_ZERO;
      wbyte[pend_idx_ff] = pend_val_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (core_rst) begin
      wr_done_ff <= 1'b0;
    end else begin
      wr_done_ff <= commit;
    end
  end

  // ==========================================================
  // read path
  always_ff @(posedge clk) begin
    if (core_rst) begin
      rd_valid_ff <= 1'b0;
      rd_data_ff  <= QBP_ALL_ZERO;
    end else begin
      rd_valid_ff <= rd_req;
      if (rd_req) begin
        if (rd_port >= 3'(QBP_NPORT)) begin
          rd_data_ff <= QBP_ALL_ZERO;
        end else if (qbp_is_rmw(rd_op)) begin
          rd_data_ff <= latch_w[rd_port];
        end else begin
          rd_data_ff <= sync_w[rd_port];
        end
      end
    end
  end

  // ==========================================================
  // driver selection: bus takeover and alternate outputs
  // during bus access port zero, and port two for 16-bit addresses, serve the bus; latch writes do not reach those pins
  assign p0_full = ~ext_data_phase | ext_drive;

  always_comb begin
    ovr_en_w  = '0;
    ovr_val_w = '0;
    alt_w     = {QBP_NPORT{QBP_LATCH_RST}};
    ovr_en_w[0] = ext_cycle;
    ovr_val_w[0] = ext_data_phase ? (ext_drive ? ext_wdata : QBP_LATCH_RST)
                                  : ext_addr[7:0];
    ovr_en_w[2] = ext_cycle & ext_addr16;
    ovr_val_w[2] = ext_addr[15:8];
    alt_w[1] = alt_out_p1 | ~QBP_P1_ALT_MASK;
    alt_w[3] = alt_out_p3 | ~QBP_P3_ALT_MASK;
  end

  // ==========================================================
  // six port units; port zero open drain without strong pullup
  for (genvar i = 0; i < QBP_NPORT; i++) begin : g_port
    qbp_port_unit #(
      .OPEN_DRAIN (i == 0),
      .HAS_STRONG (i != 0)
    ) u_port (
      .clk        (clk),
      .rst        (core_rst),
      .load_ph1   (load_ph1),
      .s1_start   (s1_start),
      .wr_en      (commit && (pend_port_ff == 3'(i))),
      .wr_data    (wbyte),
      .force_ones ((i == 0) && ext_cycle),
      .ovr_en     (ovr_en_w[i]),
      .ovr_val    (ovr_val_w[i]),
      .ovr_full   (p0_full),
      .alt_out    (alt_w[i]),
      .pin_in     (pin_in[i]),
      .latch_q    (latch_w[i]),
      .pin_sync   (sync_w[i]),
      .pin_out    (pin_out[i]),
      .pin_oe     (pin_oe[i]),
      .pin_strong (pin_strong[i])
    );
  end

  // live pin levels, not latches, feed the alternate inputs
  assign alt_in_p1        = sync_w[1];
  assign alt_in_p3        = sync_w[3];
  assign ext_rdata        = sync_w[0];
  assign rd_data          = rd_data_ff;
  assign rd_valid         = rd_valid_ff;
  assign wr_done          = wr_done_ff;
  assign mc_phase         = cnt_w;
  assign pin_reset_active = irst_w;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_latch_s6p2;
    !$stable(latch_w[1]) |-> $past(cnt_w) == QBP_LAST_PH || $past(core_rst);
  endproperty
  a_latch_s6p2: assert property (p_latch_s6p2)
    else $error("port one latch changed outside S6P2");

  property p_pin_phase1;
    !$stable(pin_out[1]) |-> !cnt_w[0] || $past(core_rst);
  endproperty
  a_pin_phase1: assert property (p_pin_phase1)
    else $error("port one pin changed outside phase 1");

  property p_strong_s1;
    |pin_strong[1] |-> cnt_w == QBP_S1P1 || cnt_w == QBP_S1P2;
  endproperty
  a_strong_s1: assert property (p_strong_s1)
    else $error("port one strong pullup outside S1");

  property p_strong_hold;
    (cnt_w == QBP_S1P1 && |pin_strong[1] && !core_rst)
      |=> pin_strong[1] == $past(pin_strong[1]) ##1 pin_strong[1] == 8'h00;
  endproperty
  a_strong_hold: assert property (p_strong_hold)
    else $error("strong pullup not held for both S1 phases");

  property p_reset_ones;
    $past(core_rst) |-> latch_w == {QBP_NPORT{QBP_LATCH_RST}};
  endproperty
  a_reset_ones: assert property (p_reset_ones)
    else $error("latches not all ones after reset");

  property p_rmw_latch;
    (rd_req && qbp_is_rmw(rd_op) && rd_port == QBP_PORT_ONE && !core_rst)
      |=> rd_valid && rd_data == $past(latch_w[1]);
  endproperty
  a_rmw_latch: assert property (p_rmw_latch)
    else $error("read-modify-write did not return the latch");

  property p_alt_gate;
    (cnt_w == QBP_S2P1 && !$past(core_rst))
      |-> pin_out[3] == ($past(latch_w[3]) & $past(alt_out_p3));
  endproperty
  a_alt_gate: assert property (p_alt_gate)
    else $error("port three pin not latch AND alternate output");

  property p_p0_ones;
    (ext_cycle && !core_rst) |=> latch_w[0] == QBP_LATCH_RST;
  endproperty
  a_p0_ones: assert property (p_p0_ones)
    else $error("port zero latch not ones during bus access");

  property p_p2_addr;
    (cnt_w == QBP_S2P1 && $past(ext_cycle && ext_addr16) && !$past(core_rst))
      |-> pin_out[2] == $past(ext_addr[15:8])
          && pin_strong[2] == $past(ext_addr[15:8]);
  endproperty
  a_p2_addr: assert property (p_p2_addr)
    else $error("port two not driving high address");

  property p_rst_filter;
    $rose(irst_w) |-> $past(cnt_w) == QBP_RST_SAMP;
  endproperty
  a_rst_filter: assert property (p_rst_filter)
    else $error("internal reset rose off the sample phase");

endmodule : qbp_port_array
`default_nettype wire

//--- bench/qbp_board.sv
// board model: pin levels from drivers, pullups, pull-downs and a memory
`timescale 1ns/100ps
`default_nettype none
module qbp_board
  import qbp_pkg::*;
(
  input  wire logic            clk,
  input  wire logic [5:0][7:0] pin_out,
  input  wire logic [5:0][7:0] pin_oe,
  input  wire logic [5:0][7:0] pin_strong,
  input  wire logic [5:0][7:0] pull_low,
  input  wire logic            mem_drv,
  input  wire logic      [7:0] mem_data,
  output logic      [5:0][7:0] pin_in
);
  logic tgl_ff = 1'b0;
  // a floating pin wanders, so a stale level never passes for data
  always_ff @(posedge clk) begin
    tgl_ff <= ~tgl_ff;
  end
  // no fetches are modelled, so the program-store strobe idles high
  localparam logic program_store_strobe_n = 1'b1;
  logic merged_rd_n;
  assign merged_rd_n = program_store_strobe_n
                       & (pin_strong[3][7] | ~pin_oe[3][7] | pin_out[3][7]);
  always_comb begin
    for (int p = 0; p < 6; p++) begin
      for (int b = 0; b < 8; b++) begin
        if (pin_strong[p][b]) pin_in[p][b] = 1'b1;
        else if (pin_oe[p][b]) pin_in[p][b] = pin_out[p][b];
        else if (pull_low[p][b]) pin_in[p][b] = 1'b0;
        else if (p != 0) pin_in[p][b] = 1'b1;
        else if (mem_drv && !merged_rd_n) pin_in[p][b] = mem_data[b];
        else pin_in[p][b] = tgl_ff ^ b[0];
      end
    end
  end
endmodule : qbp_board
`default_nettype wire

//--- bench/tb_top.sv
// self-checking bench of the port array
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import qbp_pkg::*;
  typedef struct packed {logic [2:0] p; logic [7:0] d; qbp_op_t op;} qbp_row_t;
  logic clk = 1'b0, reset = 1'b1, ext_reset_n = 1'b1, wr_req = 1'b0, wr_bit = 1'b0;
  logic wr_bit_val = 1'b0, rd_req = 1'b0, ext_cycle = 1'b0, ext_addr16 = 1'b0;
  logic ext_data_phase = 1'b0, ext_drive = 1'b0, mem_drv = 1'b0, hit;
  logic [2:0] wr_port = 3'h0, wr_bit_idx = 3'h0, rd_port = 3'h0;
  logic [7:0] wr_data = 8'h00, ext_wdata = 8'h00, mem_data = 8'h00, es, pv;
  logic [7:0] alt_out_p1 = 8'hff, alt_out_p3 = 8'hff;
  logic [7:0] rd_data, alt_in_p1, alt_in_p3, ext_rdata;
  logic [15:0] ext_addr = 16'h0000;
  qbp_op_t rd_op = op_plain_read;
  logic [5:0][7:0] pin_in, pin_out, pin_oe, pin_strong, pull_low = '0;
  logic rd_valid, wr_done, pin_reset_active;
  logic [3:0] mc_phase;
  logic [7:0] lat [6];
  int err_total = 0, checks = 0;
  qbp_row_t rows [11] = '{
    '{3'h1, 8'h00, logical_and_op}, '{3'h1, 8'hff, logical_or_op},
    '{3'h2, 8'ha5, logical_xor_op}, '{3'h3, 8'h3c, jump_bit_set_clear_op},
    '{3'h4, 8'h00, complement_bit_op}, '{3'h5, 8'h81, op_increment},
    '{3'h0, 8'h00, op_decrement}, '{3'h0, 8'hff, decrement_jump_nonzero_op},
    '{3'h4, 8'hf0, op_move_carry_bit}, '{3'h5, 8'h7e, op_clear_bit},
    '{3'h2, 8'h5a, op_set_bit}};

  always #20 clk = ~clk;

  qbp_port_array qbp_port_array_inst (.clk, .reset, .ext_reset_n, .wr_req, .wr_port,
    .wr_data, .wr_bit, .wr_bit_idx, .wr_bit_val, .rd_req, .rd_port, .rd_op, .ext_cycle,
    .ext_addr16, .ext_addr, .ext_data_phase, .ext_drive, .ext_wdata, .alt_out_p1,
    .alt_out_p3, .pin_in, .pin_out, .pin_oe, .pin_strong, .rd_data, .rd_valid, .wr_done,
    .alt_in_p1, .alt_in_p3, .ext_rdata, .mc_phase, .pin_reset_active);
  qbp_board qbp_board_inst (.clk, .pin_out, .pin_oe, .pin_strong, .pull_low, .mem_drv,
    .mem_data, .pin_in);

  // ==========
  // shared tasks
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp8
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : cyc
  task automatic wt_done;
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (wr_done !== 1'b1 && n < 15);
    cmp8({7'h00, wr_done}, 8'h01, "wr_done");
  endtask : wt_done
  task automatic wr(input logic [2:0] p, input logic [7:0] d, input logic b,
                    input logic [2:0] i, input logic v);
    @(posedge clk);
    wr_req <= 1'b1;
    wr_port <= p;
    wr_data <= d;
    wr_bit <= b;
    wr_bit_idx <= i;
    wr_bit_val <= v;
    @(posedge clk);
    wr_req <= 1'b0;
    wt_done;
  endtask : wr
  task automatic rd(input logic [2:0] p, input qbp_op_t op, input logic [7:0] exp);
    @(posedge clk);
    rd_req <= 1'b1;
    rd_port <= p;
    rd_op <= op;
    @(posedge clk);
    rd_req <= 1'b0;
    @(negedge clk);
    cmp8({7'h00, rd_valid}, 8'h01, "rd_valid");
    cmp8(rd_data, exp, "rd_data");
  endtask : rd
  task automatic test_done;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    test_done;
  end

  // ==========
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    cmp8({6'h00, rd_valid, wr_done}, 8'h00, "strobes");
    cmp8(rd_data, QBP_ALL_ZERO, "rd_data rst");
    for (int p = 0; p < 6; p++) begin
      lat[p] = QBP_LATCH_RST;
      cmp8(pin_out[p], QBP_LATCH_RST, "pin rst");
      cmp8(pin_oe[p] | pin_strong[p], 8'h00, "oe rst");
      rd(3'(p), logical_or_op, QBP_LATCH_RST);
    end
    hit = 1'b0;
    for (int n = 0; n < 13 && !hit; n++) begin
      @(negedge clk);
      hit = (mc_phase === QBP_S1P1);
    end
    cyc(6);
    cmp8({4'h0, mc_phase}, 8'h06, "phase mid");
    cyc(6);
    cmp8({4'h0, mc_phase}, 8'h00, "phase wrap");
    $display("reset and phase test done");

    foreach (rows[r]) begin
      pv = lat[rows[r].p];
      wr(rows[r].p, rows[r].d, 1'b0, 3'h0, 1'b0);
      lat[rows[r].p] = rows[r].d;
      es = (rows[r].p == 3'h0) ? 8'h00 : (~pv & rows[r].d);
      cmp8({4'h0, mc_phase}, {4'h0, QBP_S1P1}, "commit phase");
      cmp8(pin_out[rows[r].p], rows[r].d, "pin");
      cmp8(pin_oe[rows[r].p] & ~es, ~rows[r].d & ~es, "oe");
      cmp8(pin_strong[rows[r].p], es, "strong p1");
      cyc(0);
      cmp8(pin_strong[rows[r].p], es, "strong p2");
      cyc(0);
      cmp8(pin_strong[rows[r].p], 8'h00, "strong off");
      rd(rows[r].p, rows[r].op, rows[r].d);
    end
    $display("row test done");

    // start at S1P1 so both captures land well before the commit edge
    while (mc_phase !== QBP_S1P1) @(negedge clk);
    @(posedge clk);
    wr_req <= 1'b1;
    wr_port <= 3'h4;
    wr_data <= 8'h11;
    wr_bit <= 1'b0;
    @(posedge clk);
    wr_data <= 8'h22;
    @(posedge clk);
    wr_req <= 1'b0;
    wt_done;
    cmp8(pin_out[4], 8'h22, "last wins");
    wr(3'h4, 8'hff, 1'b1, 3'h5, 1'b0);
    rd(3'h4, jump_bit_set_clear_op, 8'h02);
    wr(3'h4, 8'h00, 1'b1, 3'h0, 1'b1);
    cmp8(pin_out[4], 8'h03, "bit set");
    lat[4] = 8'h03;
    @(posedge clk);
    wr_req <= 1'b1;
    wr_port <= 3'h6;
    wr_data <= 8'h00;
    wr_bit <= 1'b0;
    @(posedge clk);
    wr_req <= 1'b0;
    cyc(14);
    for (int p = 0; p < 6; p++) cmp8(pin_out[p], lat[p], "no port six");
    rd(3'h6, logical_and_op, 8'h00);
    $display("write order test done");

    @(posedge clk);
    pull_low[1] <= 8'h04;
    pull_low[3] <= 8'h04;
    cyc(4);
    rd(3'h1, op_plain_read, 8'hfb);
    rd(3'h1, complement_bit_op, 8'hff);
    cmp8(alt_in_p1, 8'hfb, "alt in p1");
    cmp8(alt_in_p3, 8'h38, "alt in p3");
    @(posedge clk);
    pull_low <= '0;
    alt_out_p1 <= 8'h5a;
    alt_out_p3 <= 8'haa;
    cyc(4);
    cmp8(pin_out[1], 8'h5f, "alt p1");
    cmp8(pin_out[3], 8'h28, "alt p3");
    @(posedge clk);
    alt_out_p1 <= 8'hff;
    alt_out_p3 <= 8'hff;
    $display("pin and alternate test done");

    wr(3'h0, 8'h00, 1'b0, 3'h0, 1'b0);
    @(posedge clk);
    ext_cycle <= 1'b1;
    ext_addr16 <= 1'b1;
    ext_addr <= 16'ha5c3;
    cyc(4);
    cmp8(pin_out[2], 8'ha5, "addr hi");
    cmp8(pin_oe[2], 8'hff, "addr hi oe");
    cmp8(pin_out[0], 8'hc3, "addr lo");
    cmp8(pin_oe[0], 8'hff, "addr lo oe");
    @(posedge clk);
    ext_data_phase <= 1'b1;
    ext_drive <= 1'b1;
    ext_wdata <= 8'h69;
    cyc(4);
    cmp8(pin_out[0], 8'h69, "wdata");
    @(posedge clk);
    ext_drive <= 1'b0;
    mem_drv <= 1'b1;
    mem_data <= 8'h96;
    cyc(4);
    cmp8(pin_oe[0], 8'h00, "read float");
    cmp8(ext_rdata, 8'h96, "rdata");
    cmp8(pin_strong[2], 8'ha5, "addr strong");
    @(posedge clk);
    ext_addr16 <= 1'b0;
    cyc(4);
    cmp8(pin_out[2], 8'h5a, "short addr");
    @(posedge clk);
    ext_cycle <= 1'b0;
    ext_data_phase <= 1'b0;
    mem_drv <= 1'b0;
    cyc(4);
    rd(3'h0, logical_or_op, 8'hff);
    rd(3'h2, logical_or_op, 8'h5a);
    $display("external bus test done");

    wr(3'h5, 8'h00, 1'b0, 3'h0, 1'b0);
    hit = 1'b0;
    @(posedge clk);
    ext_reset_n <= 1'b0;
    repeat (8) @(posedge clk);
    ext_reset_n <= 1'b1;
    repeat (30) begin
      @(negedge clk);
      hit = hit | (pin_reset_active === 1'b1);
    end
    cmp8({7'h00, hit}, 8'h00, "short pulse");
    @(posedge clk);
    ext_reset_n <= 1'b0;
    cyc(36);
    cmp8({7'h00, pin_reset_active}, 8'h01, "pin reset");
    cmp8(pin_out[5], QBP_LATCH_RST, "pin reset latch");
    @(posedge clk);
    ext_reset_n <= 1'b1;
    for (int n = 0; n < 16 && pin_reset_active !== 1'b0; n++) @(negedge clk);
    cmp8({7'h00, pin_reset_active}, 8'h00, "pin release");
    rd(3'h5, op_clear_bit, QBP_LATCH_RST);
    $display("pin reset test done");
    test_done;
  end
endmodule : tb_top
`default_nettype wire
